// >>> rtl/gp_timer_pkg.sv
/*
  Constants for the 16-bit gated, prescaled timer: register indices, control field
  positions, interrupt bit positions, reset values and prescaler divides.
  Assumes: byte address on the APB bus is four times the register index.
*/
package gp_timer_pkg;

  // ==========================================================================
  // register indices (byte address = index * 4)
  localparam logic [15:0] COUNT_IDX = 16'h0100;
  localparam logic [15:0] PERIOD_IDX = 16'h0102;
  localparam logic [15:0] CONTROL_IDX = 16'h0104;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'h0106;
  localparam logic [15:0] IRQ_MASK_IDX = 16'h0108;
  localparam int ADDR_W = 18;

  // ==========================================================================
  // control register fields
  localparam int TIMER_ON_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int GATE_ACC_BIT = 6;
  localparam int PRESCALE_LSB = 4;
  localparam int SYNC_SEL_BIT = 2;
  localparam int SRC_SEL_BIT = 1;
  localparam logic [15:0] CONTROL_MASK = 16'hA076;

  // ==========================================================================
  // interrupt status and mask bits
  localparam int IRQ_W = 2;
  localparam int IRQ_MATCH_BIT = 0;
  localparam int IRQ_GATE_BIT = 1;

  // ==========================================================================
  // reset values
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CONTROL_RST = 16'h0000;

  // ==========================================================================
  // prescaler terminal counts for divide by 1, 8, 64 and 256
  localparam logic [7:0] DIV1_LAST = 8'h00;
  localparam logic [7:0] DIV8_LAST = 8'h07;
  localparam logic [7:0] DIV64_LAST = 8'h3F;
  localparam logic [7:0] DIV256_LAST = 8'hFF;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

endpackage

// >>> rtl/gp_timer16.sv
/*
  16-bit general purpose timer/counter with period register, gate accumulation,
  four-step prescaler, Idle/Sleep behaviour and an APB register interface.
  Assumes: one 200 MHz clock, one CLK cycle is one instruction cycle, CPU_IDLE and
  CPU_SLEEP come from logic on CLK, the external clock/gate pin is asynchronous.
*/
// Added by the designer: the register addresses and the APB interface to the registers.
// Behaviour
// - internal mode counts cycles, wraps at period
// - idle halts counting when idle halt set
// - sync mode counts synchronised external rising edges
// - async mode counts the same synchronised external rising edges
// - async mode also halts in idle
// - gate mode counts cycles while pin high
// - prescaler divides by 1, 8, 64, 256
// - prescaler cleared by count/control write, reset
// - prescaler clear needs timer switched on
// - control write keeps count; count write sets
// - sleep counting only when on, external, async
// - interrupt on match and gate falling edge
// - flag set by hardware, cleared by software
`timescale 1ns/10ps
module gp_timer16 (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gp_timer_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CPU_IDLE,
  input wire logic CPU_SLEEP,
  input wire logic GATE_CLOCK_PIN,
  output logic IRQ
);

  // ==========================================================================
  // state
  gp_timer_pkg::bus_state_t bus_state_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic [15:0] timer_count_reg_ff;
  logic [15:0] period_match_reg_ff;
  logic [15:0] timer_control_reg_ff;
  logic [gp_timer_pkg::IRQ_W-1:0] timer_irq_flag_ff;
  logic [gp_timer_pkg::IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;
  logic [7:0] prescale_cnt_ff;
  logic pin_meta_ff;
  logic pin_sync_ff;
  logic pin_prev_ff;

  // ==========================================================================
  // bus decode
  logic [15:0] reg_idx;
  logic addr_ok;
  logic access_done;
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_status;
  logic wr_mask;
  logic [31:0] nxt_prdata;

  assign reg_idx = PADDR[gp_timer_pkg::ADDR_W-1:2];
  assign addr_ok = (PADDR[1:0] == 2'h0) &&
    (reg_idx == gp_timer_pkg::COUNT_IDX || reg_idx == gp_timer_pkg::PERIOD_IDX ||
     reg_idx == gp_timer_pkg::CONTROL_IDX || reg_idx == gp_timer_pkg::IRQ_STATUS_IDX ||
     reg_idx == gp_timer_pkg::IRQ_MASK_IDX);
  assign access_done = (bus_state_ff == gp_timer_pkg::BUS_ACK) && PSEL && PENABLE;
  assign wr_count = access_done && PWRITE && addr_ok && (reg_idx == gp_timer_pkg::COUNT_IDX);
  assign wr_period = access_done && PWRITE && addr_ok && (reg_idx == gp_timer_pkg::PERIOD_IDX);
  assign wr_control = access_done && PWRITE && addr_ok && (reg_idx == gp_timer_pkg::CONTROL_IDX);
  assign wr_status = access_done && PWRITE && addr_ok && (reg_idx == gp_timer_pkg::IRQ_STATUS_IDX);
  assign wr_mask = access_done && PWRITE && addr_ok && (reg_idx == gp_timer_pkg::IRQ_MASK_IDX);

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (addr_ok && !PWRITE) begin
      case (reg_idx)
        gp_timer_pkg::COUNT_IDX: nxt_prdata = {16'h0000, timer_count_reg_ff};
        gp_timer_pkg::PERIOD_IDX: nxt_prdata = {16'h0000, period_match_reg_ff};
        gp_timer_pkg::CONTROL_IDX: nxt_prdata = {16'h0000, timer_control_reg_ff};
        gp_timer_pkg::IRQ_STATUS_IDX: nxt_prdata = {30'h0000_0000, timer_irq_flag_ff};
        gp_timer_pkg::IRQ_MASK_IDX: nxt_prdata = {30'h0000_0000, irq_mask_ff};
        default: nxt_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // apb handshake: one wait cycle, answer registered
  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_state_ff <= gp_timer_pkg::BUS_IDLE;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      case (bus_state_ff)
        gp_timer_pkg::BUS_IDLE: begin
          if (PSEL && PENABLE) begin
            bus_state_ff <= gp_timer_pkg::BUS_ACK;
            prdata_ff <= nxt_prdata;
            pslverr_ff <= !addr_ok;
          end
        end
        gp_timer_pkg::BUS_ACK: begin
          bus_state_ff <= gp_timer_pkg::BUS_IDLE;
          pslverr_ff <= 1'b0;
        end
        default: bus_state_ff <= gp_timer_pkg::BUS_IDLE;
      endcase
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = (bus_state_ff == gp_timer_pkg::BUS_ACK);
  assign PSLVERR = pslverr_ff;

  // ==========================================================================
  // control fields
  logic timer_on;
  logic idle_halt_select;
  logic gate_accumulate_enable;
  logic external_sync_select;
  logic clock_source_select;
  logic [1:0] prescale_select;

  assign timer_on = timer_control_reg_ff[gp_timer_pkg::TIMER_ON_BIT];
  assign idle_halt_select = timer_control_reg_ff[gp_timer_pkg::IDLE_HALT_BIT];
  assign gate_accumulate_enable = timer_control_reg_ff[gp_timer_pkg::GATE_ACC_BIT];
  assign external_sync_select = timer_control_reg_ff[gp_timer_pkg::SYNC_SEL_BIT];
  assign clock_source_select = timer_control_reg_ff[gp_timer_pkg::SRC_SEL_BIT];
  assign prescale_select = timer_control_reg_ff[gp_timer_pkg::PRESCALE_LSB +: 2];

  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_control_reg_ff <= gp_timer_pkg::CONTROL_RST;
      period_match_reg_ff <= gp_timer_pkg::PERIOD_RST;
      irq_mask_ff <= '0;
    end else begin
      if (wr_control) begin
        timer_control_reg_ff <= PWDATA[15:0] & gp_timer_pkg::CONTROL_MASK;
      end
      if (wr_period) begin
        period_match_reg_ff <= PWDATA[15:0];
      end
      if (wr_mask) begin
        irq_mask_ff <= PWDATA[gp_timer_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // external clock / gate pin synchroniser
  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_meta_ff <= 1'b0;
      pin_sync_ff <= 1'b0;
      pin_prev_ff <= 1'b0;
    end else begin
      pin_meta_ff <= GATE_CLOCK_PIN;
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  logic pin_rise;
  logic pin_fall;
  assign pin_rise = pin_sync_ff && !pin_prev_ff;
  assign pin_fall = !pin_sync_ff && pin_prev_ff;

  // ==========================================================================
  // run conditions and raw input clock
  logic run_ok;
  logic raw_tick;
  logic sleep_ok;

  // sleep keeps only the asynchronous external counter alive
  assign sleep_ok = !CPU_SLEEP || (clock_source_select && !external_sync_select);
  assign run_ok = timer_on && sleep_ok && !(CPU_IDLE && idle_halt_select);

  always_comb begin
    raw_tick = 1'b0;
    if (clock_source_select) begin
      // sync and async both use the pin edge; single clock forces sampling
      raw_tick = pin_rise;
    end else if (gate_accumulate_enable) begin
      raw_tick = pin_sync_ff;
    end else begin
      raw_tick = 1'b1;
    end
  end

  // ==========================================================================
  // prescaler
  logic [7:0] prescale_last;
  logic prescale_tick;
  logic prescale_clear;

  always_comb begin
    case (prescale_select)
      2'h0: prescale_last = gp_timer_pkg::DIV1_LAST;
      2'h1: prescale_last = gp_timer_pkg::DIV8_LAST;
      2'h2: prescale_last = gp_timer_pkg::DIV64_LAST;
      default: prescale_last = gp_timer_pkg::DIV256_LAST;
    endcase
  end

  // prescaler clock halts while off, so no clear then
  assign prescale_clear = (wr_count || wr_control) && timer_on;
  assign prescale_tick = run_ok && raw_tick && (prescale_cnt_ff >= prescale_last);

  always_ff @(posedge CLK) begin
    if (RST) begin
      prescale_cnt_ff <= 8'h00;
    end else if (prescale_clear) begin
      prescale_cnt_ff <= 8'h00;
    end else if (run_ok && raw_tick) begin
      if (prescale_cnt_ff >= prescale_last) begin
        prescale_cnt_ff <= 8'h00;
      end else begin
        prescale_cnt_ff <= prescale_cnt_ff + 8'h01;
      end
    end
  end

  // ==========================================================================
  // counter
  logic period_hit;
  assign period_hit = prescale_tick && (timer_count_reg_ff == period_match_reg_ff);

  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_count_reg_ff <= gp_timer_pkg::COUNT_RST;
    end else if (wr_count) begin
      // control writes never touch the count
      timer_count_reg_ff <= PWDATA[15:0];
    end else if (period_hit) begin
      timer_count_reg_ff <= 16'h0000;
    end else if (prescale_tick) begin
      timer_count_reg_ff <= timer_count_reg_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // interrupt flags: set wins over write-one-to-clear
  logic [gp_timer_pkg::IRQ_W-1:0] irq_set;
  logic [gp_timer_pkg::IRQ_W-1:0] irq_clr;
  logic gate_end;

  assign gate_end = timer_on && gate_accumulate_enable && !clock_source_select && pin_fall;
  assign irq_set[gp_timer_pkg::IRQ_MATCH_BIT] = period_hit;
  assign irq_set[gp_timer_pkg::IRQ_GATE_BIT] = gate_end;
  assign irq_clr = wr_status ? PWDATA[gp_timer_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_irq_flag_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      timer_irq_flag_ff <= (timer_irq_flag_ff & ~irq_clr) | irq_set;
      irq_ff <= |(((timer_irq_flag_ff & ~irq_clr) | irq_set) & irq_mask_ff);
    end
  end

  assign IRQ = irq_ff;

endmodule // gp_timer16

// >>> bench/gp_timer16_chk.sv
/* checker: bus handshake and interrupt properties on the timer ports
   assumes: bound to gp_timer16 from the bench top */
`timescale 1ns/10ps
module gp_timer16_chk (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gp_timer_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic CPU_IDLE,
  input wire logic CPU_SLEEP,
  input wire logic GATE_CLOCK_PIN,
  input wire logic IRQ
);
  // ==========================================================================
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_ready_access: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  a_ready_cause: assert property (PREADY |-> PSEL && PENABLE && $past(PENABLE)) else $error("ready early");
  a_err_ready: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  a_err_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("error data");
  a_upper_zero: assert property (PREADY && !PWRITE |-> PRDATA[31:16] == 16'h0000) else $error("upper bits");
  a_ctrl_rsvd: assert property (PREADY && !PWRITE && PADDR == 18'h00410
    |-> (PRDATA[15:0] & ~gp_timer_pkg::CONTROL_MASK) == 16'h0000) else $error("reserved bits");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(PSEL && PENABLE && PWRITE && PREADY, 1))
    else $error("irq cleared by hardware");
  a_reset_quiet: assert property ($fell(RST) |-> !IRQ && !PREADY && !PSLVERR) else $error("reset outputs");
endmodule // gp_timer16_chk

// >>> bench/gate_clk_src.sv
/* external clock and gate source driving the timer pin
   assumes: tasks are called from the bench on its clock */
`timescale 1ns/10ps
module gate_clk_src (
  input wire logic clk,
  output logic pin
);
  // ==========================================================================
  // pin stays low outside bursts
  initial pin = 1'b0;
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clk);
      pin <= 1'b1;
      repeat (3) @(posedge clk);
      pin <= 1'b0;
      repeat (2) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask
  task automatic high(input int n);
    @(posedge clk);
    pin <= 1'b1;
    repeat (n) @(posedge clk);
    pin <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
endmodule // gate_clk_src

// >>> bench/tb_gp_timer16.sv
/* bench for gp_timer16: registers, counting modes, prescaler, interrupts
   assumes: gate_clk_src drives the pin, checker bound at the foot */
`timescale 1ns/10ps
module tb_gp_timer16;
  logic CLK, RST, PSEL, PENABLE, PWRITE, CPU_IDLE, CPU_SLEEP, PREADY, PSLVERR, IRQ, GATE_CLOCK_PIN, e;
  logic [17:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  int errors = 0;
  int samples_checked = 0;
  localparam logic [17:0] CNT = 18'h00400, PER = 18'h00408, CTL = 18'h00410, STA = 18'h00418, MSK = 18'h00420;
  gp_timer16 i_gp_timer16 (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP), .GATE_CLOCK_PIN(GATE_CLOCK_PIN), .IRQ(IRQ));
  gate_clk_src i_gate_clk_src (.clk(CLK), .pin(GATE_CLOCK_PIN));
  // ==========================================================================
  // helpers
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    n = 0;
    // hold the request until pready is seen high at a rising edge
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 40);
    if (PREADY !== 1'b1) begin
      errors++;
      $display("[ERR] pready expected 1 seen %b", PREADY);
    end
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, q, x);
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    rd(CNT, 32'h0, "count rst");
    rd(PER, 32'hFFFF, "period rst");
    rd(CTL, 32'h0, "control rst");
    apb(1'b0, 18'h003FC, 32'h0);
    chk("unmapped err", {31'h0, e}, 32'h1);
  endtask
  task automatic t_ext;
    apb(1'b1, PER, 32'h5);
    apb(1'b1, MSK, 32'h1);
    apb(1'b1, CTL, 32'h8006);
    apb(1'b1, CNT, 32'h0);
    i_gate_clk_src.edges(7);
    rd(CNT, 32'h1, "sync wrap");
    rd(STA, 32'h1, "match flag");
    chk("irq", {31'h0, IRQ}, 32'h1);
    apb(1'b1, STA, 32'h1);
    repeat (2) @(negedge CLK);
    chk("irq clear", {31'h0, IRQ}, 32'h0);
    apb(1'b1, PER, 32'hFFFF);
  endtask
  task automatic t_pre;
    int dv[4] = '{1, 8, 64, 256};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, CTL, 32'h8006 | (k << 4));
      apb(1'b1, CNT, 32'h0);
      i_gate_clk_src.edges(dv[k] - 1);
      rd(CNT, 32'h0, "below div");
      i_gate_clk_src.edges(1);
      rd(CNT, 32'h1, "at div");
    end
    apb(1'b1, CNT, 32'h0);
    i_gate_clk_src.edges(4);
    apb(1'b1, CTL, 32'h8016);
    i_gate_clk_src.edges(4);
    rd(CNT, 32'h0, "pre clear");
  endtask
  task automatic t_idle;
    apb(1'b1, CTL, 32'hA006);
    apb(1'b1, CNT, 32'h0);
    CPU_IDLE <= 1'b1;
    i_gate_clk_src.edges(3);
    rd(CNT, 32'h0, "idle halt");
    CPU_IDLE <= 1'b0;
    i_gate_clk_src.edges(3);
    rd(CNT, 32'h3, "idle resume");
    apb(1'b1, CTL, 32'hA002);
    CPU_IDLE <= 1'b1;
    i_gate_clk_src.edges(2);
    rd(CNT, 32'h3, "async idle");
    apb(1'b1, CTL, 32'h8002);
    i_gate_clk_src.edges(2);
    rd(CNT, 32'h5, "idle run");
    CPU_IDLE <= 1'b0;
  endtask
  task automatic t_sleep;
    apb(1'b1, CNT, 32'h0);
    CPU_SLEEP <= 1'b1;
    i_gate_clk_src.edges(4);
    rd(CNT, 32'h4, "sleep async");
    apb(1'b1, CTL, 32'h8006);
    rd(CNT, 32'h4, "ctl keeps count");
    i_gate_clk_src.edges(4);
    rd(CNT, 32'h4, "sleep sync");
    CPU_SLEEP <= 1'b0;
  endtask
  task automatic t_gate;
    apb(1'b1, MSK, 32'h2);
    apb(1'b1, CTL, 32'h8040);
    apb(1'b1, CNT, 32'h0);
    i_gate_clk_src.high(10);
    rd(CNT, 32'hA, "gate count");
    rd(STA, 32'h2, "gate fall");
    chk("gate irq", {31'h0, IRQ}, 32'h1);
    apb(1'b1, STA, 32'h3);
  endtask
  task automatic t_int;
    apb(1'b1, MSK, 32'h1);
    apb(1'b1, PER, 32'h3);
    apb(1'b1, CNT, 32'h0);
    apb(1'b1, CTL, 32'h8000);
    repeat (10) @(posedge CLK);
    apb(1'b1, CTL, 32'h0);
    rd(STA, 32'h1, "int match");
    apb(1'b0, CNT, 32'h0);
    chk("int range", {31'h0, q <= 32'h3}, 32'h1);
  endtask
  // ==========================================================================
  // clock, sequence, watchdog
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    RST = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 18'h0;
    PWDATA = 32'h0;
    CPU_IDLE = 1'b0;
    CPU_SLEEP = 1'b0;
    repeat (10) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_ext();
    t_pre();
    t_idle();
    t_sleep();
    t_gate();
    t_int();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge CLK);
    errors++;
    stop_test();
  end
endmodule // tb_gp_timer16
bind gp_timer16 gp_timer16_chk i_chk (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .CPU_IDLE(CPU_IDLE), .CPU_SLEEP(CPU_SLEEP), .GATE_CLOCK_PIN(GATE_CLOCK_PIN), .IRQ(IRQ));
